// [pkg/eopt_defines.svh]
`ifndef EOPT_DEFINES_SVH
`define EOPT_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define EOPT_OFS_CTRL 8'h00
`define EOPT_OFS_OFFSET 8'h04
`define EOPT_OFS_GAIN 8'h08
`define EOPT_OFS_PHASE 8'h0C
`define EOPT_OFS_NUM 8'h10
`define EOPT_OFS_DEN 8'h14
`define EOPT_OFS_HCYC 8'h18
`define EOPT_OFS_ENERGY 8'h1C
`define EOPT_OFS_LENERGY 8'h20
`define EOPT_OFS_STATUS 8'h24
`define EOPT_OFS_IRQ_EN 8'h28
`define EOPT_OFS_IRQ_CLR 8'h2C

// ==========================================================
// Reset values
`define EOPT_RST_PHASE 6'h0D
`define EOPT_RST_NUM 12'h03F
`define EOPT_RST_DEN 12'h03F
`define EOPT_RST_HCYC 16'h0000

// ==========================================================
// Field positions and widths
`define EOPT_CTRL_LINE_MODE 0
`define EOPT_ST_LINE_DONE 0
`define EOPT_ST_PULSE 1
`define EOPT_ST_NEG 2
`define EOPT_ST_W 3
`define EOPT_FRAC_BITS 33
`define EOPT_ACC_W 57
`define EOPT_GAIN_ONE 14'sh1000
`define EOPT_GAIN_SHIFT 12

// ==========================================================
// Timing
`define EOPT_PHASE_MID 6'h0D
`define EOPT_PHASE_STEP_CLK 8
`define EOPT_ACC_STEP_CLK 4
`define EOPT_DIV_W 3

`endif

// [pkg/eopt_pkg.sv]
`include "eopt_defines.svh"

package eopt_pkg;

  typedef enum logic [1:0] {
    LC_IDLE = 2'b00,
    LC_ARM = 2'b01,
    LC_RUN = 2'b11
  } eopt_lc_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } eopt_apb_req_t;

  typedef struct packed {
    logic signed [15:0] volt;
    logic signed [15:0] curr;
  } eopt_sample_t;

  typedef struct packed {
    logic line_mode;
    logic signed [15:0] offset;
    logic signed [11:0] gain;
    logic signed [5:0] phase;
    logic [11:0] num;
    logic [11:0] den;
    logic [15:0] hcyc_set;
    logic [`EOPT_ST_W-1:0] irq_en;
    logic [`EOPT_ST_W-1:0] status;
    logic [`EOPT_DIV_W-1:0] div;
    logic signed [31:0] power;
    logic signed [`EOPT_ACC_W-1:0] acc;
    logic [23:0] energy_rd;
    logic [23:0] line_energy;
    logic [23:0] line_start;
    logic [15:0] hcyc_cnt;
    eopt_lc_state_t lstate;
    logic [12:0] pulse_acc;
    logic pulse;
    logic zx_meta;
    logic zx_sync;
    logic zx_prev;
    logic [31:0] rdata;
  } eopt_state_t;

endpackage

// [src/eopt_delay_line.sv]
`timescale 1ns/1ps

module eopt_delay_line #(
  parameter int W = 16,
  parameter int DEPTH = 32,
  parameter int SELW = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic shift_en,
  input wire logic [W-1:0] din,
  input wire logic [SELW-1:0] sel,
  output logic [W-1:0] dout
);

  // ==========================================================
  // Tapped shift line, one entry per step
  logic [DEPTH-1:0][W-1:0] mem_ff;
  logic [DEPTH-1:0][W-1:0] nxt_mem;
  logic [W-1:0] dout_ff;
  logic [W-1:0] nxt_dout;

  always_comb begin
    nxt_mem = mem_ff;
    nxt_dout = dout_ff;
    if (shift_en) begin
      nxt_mem = {mem_ff[DEPTH-2:0], din};
      nxt_dout = mem_ff[sel];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ff <= '0;
      dout_ff <= '0;
    end else begin
      mem_ff <= nxt_mem;
      dout_ff <= nxt_dout;
    end
  end

  assign dout = dout_ff;

endmodule // eopt_delay_line

// [src/eopt_core.sv]
`timescale 1ns/1ps
`include "eopt_defines.svh"

module eopt_core #(
  parameter int DLY_DEPTH = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input eopt_pkg::eopt_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input eopt_pkg::eopt_sample_t sample,
  input wire logic zero_cross,
  output logic energy_pulse_output,
  output logic irq_n
);

  // ==========================================================
  // State
  eopt_pkg::eopt_state_t st_ff;
  eopt_pkg::eopt_state_t nxt_st;

  logic en4;
  logic en8;
  logic setup;
  logic wr;
  logic mapped;
  logic signed [15:0] volt_dly;
  logic signed [15:0] curr_dly;
  logic [4:0] vsel;
  logic [4:0] csel;
  logic signed [13:0] gain_fac;
  logic signed [45:0] gprod;
  logic signed [31:0] gp;
  logic signed [`EOPT_ACC_W-1:0] acc_sum;
  logic [23:0] int_new;
  logic [12:0] pulse_sum;
  logic zx_edge;
  logic [15:0] hcyc_next;
  logic [`EOPT_ST_W-1:0] ev_set;
  logic [`EOPT_ST_W-1:0] ev_clr;

  // ==========================================================
  // Step enables from one divider
  assign en4 = (st_ff.div[1:0] == 2'h3);
  assign en8 = (st_ff.div == 3'h7);

  // ==========================================================
  // Phase trim: voltage tap vs fixed current tap
  always_comb begin
    if (st_ff.phase < 6'sh00) begin
      vsel = 5'h00;
    end else begin
      vsel = st_ff.phase[4:0];
    end
  end
  assign csel = 5'(`EOPT_PHASE_MID);

  eopt_delay_line #(
    .W(16),
    .DEPTH(DLY_DEPTH),
    .SELW(5)
  ) u_volt_dly (
    .pclk(pclk),
    .presetn(presetn),
    .shift_en(en8),
    .din(sample.volt),
    .sel(vsel),
    .dout(volt_dly)
  );

  eopt_delay_line #(
    .W(16),
    .DEPTH(DLY_DEPTH),
    .SELW(5)
  ) u_curr_dly (
    .pclk(pclk),
    .presetn(presetn),
    .shift_en(en8),
    .din(sample.curr),
    .sel(csel),
    .dout(curr_dly)
  );

  // ==========================================================
  // Gain, offset and accumulation
  assign gain_fac = {{2{st_ff.gain[11]}}, st_ff.gain} + `EOPT_GAIN_ONE;
  assign gprod = st_ff.power * gain_fac;
  assign gp = gprod[43:12];
  assign acc_sum = st_ff.acc + `EOPT_ACC_W'(gp)
    + `EOPT_ACC_W'(st_ff.offset);
  assign int_new = acc_sum[`EOPT_ACC_W-1:`EOPT_FRAC_BITS];
  assign pulse_sum = st_ff.pulse_acc + {1'b0, st_ff.num} + 13'h0001;

  // ==========================================================
  // Line-cycle helpers
  assign zx_edge = st_ff.zx_sync ^ st_ff.zx_prev;
  assign hcyc_next = st_ff.hcyc_cnt + 16'h0001;

  // ==========================================================
  // Bus decode
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  always_comb begin
    case (apb_req.paddr)
      `EOPT_OFS_CTRL, `EOPT_OFS_OFFSET, `EOPT_OFS_GAIN, `EOPT_OFS_PHASE,
      `EOPT_OFS_NUM, `EOPT_OFS_DEN, `EOPT_OFS_HCYC, `EOPT_OFS_ENERGY,
      `EOPT_OFS_LENERGY, `EOPT_OFS_STATUS, `EOPT_OFS_IRQ_EN,
      `EOPT_OFS_IRQ_CLR: mapped = (apb_req.paddr[1:0] == 2'h0);
      default: mapped = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = apb_req.psel && apb_req.penable && !mapped;

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    ev_set = '0;
    ev_clr = '0;
    nxt_st.div = st_ff.div + 3'h1;
    nxt_st.pulse = 1'b0;
    nxt_st.zx_meta = zero_cross;
    nxt_st.zx_sync = st_ff.zx_meta;
    nxt_st.zx_prev = st_ff.zx_sync;

    if (en4) begin
      nxt_st.power = volt_dly * curr_dly;
      nxt_st.acc = acc_sum;
      nxt_st.energy_rd = int_new;
      if (acc_sum[`EOPT_ACC_W-1] && !st_ff.acc[`EOPT_ACC_W-1]) begin
        ev_set[`EOPT_ST_NEG] = 1'b1;
      end
      if (int_new != st_ff.energy_rd && !acc_sum[`EOPT_ACC_W-1]
          && int_new == st_ff.energy_rd + 24'h000001) begin
        if (pulse_sum >= {1'b0, st_ff.den} + 13'h0001) begin
          // Cap remainder, no wrap when ratio is above one
          if (pulse_sum - {1'b0, st_ff.den} - 13'h0001 > {1'b0, st_ff.den}) begin
            nxt_st.pulse_acc = {1'b0, st_ff.den};
          end else begin
            nxt_st.pulse_acc = pulse_sum - {1'b0, st_ff.den} - 13'h0001;
          end
          nxt_st.pulse = 1'b1;
          ev_set[`EOPT_ST_PULSE] = 1'b1;
        end else begin
          nxt_st.pulse_acc = pulse_sum;
        end
      end
    end

    case (st_ff.lstate)
      eopt_pkg::LC_IDLE: begin
        if (st_ff.line_mode) begin
          nxt_st.lstate = eopt_pkg::LC_ARM;
        end
      end
      eopt_pkg::LC_ARM: begin
        if (!st_ff.line_mode) begin
          nxt_st.lstate = eopt_pkg::LC_IDLE;
        end else if (zx_edge) begin
          nxt_st.lstate = eopt_pkg::LC_RUN;
          nxt_st.line_start = st_ff.energy_rd;
          nxt_st.hcyc_cnt = 16'h0000;
        end
      end
      eopt_pkg::LC_RUN: begin
        if (!st_ff.line_mode) begin
          nxt_st.lstate = eopt_pkg::LC_IDLE;
        end else if (zx_edge) begin
          if (hcyc_next >= st_ff.hcyc_set) begin
            nxt_st.line_energy = st_ff.energy_rd - st_ff.line_start;
            nxt_st.line_start = st_ff.energy_rd;
            nxt_st.hcyc_cnt = 16'h0000;
            ev_set[`EOPT_ST_LINE_DONE] = 1'b1;
          end else begin
            nxt_st.hcyc_cnt = hcyc_next;
          end
        end
      end
      default: nxt_st.lstate = eopt_pkg::LC_IDLE;
    endcase

    if (wr) begin
      case (apb_req.paddr)
        `EOPT_OFS_CTRL: nxt_st.line_mode = apb_req.pwdata[`EOPT_CTRL_LINE_MODE];
        `EOPT_OFS_OFFSET: nxt_st.offset = apb_req.pwdata[15:0];
        `EOPT_OFS_GAIN: nxt_st.gain = apb_req.pwdata[11:0];
        `EOPT_OFS_PHASE: nxt_st.phase = apb_req.pwdata[5:0];
        `EOPT_OFS_NUM: nxt_st.num = apb_req.pwdata[11:0];
        `EOPT_OFS_DEN: nxt_st.den = apb_req.pwdata[11:0];
        `EOPT_OFS_HCYC: nxt_st.hcyc_set = apb_req.pwdata[15:0];
        `EOPT_OFS_IRQ_EN: nxt_st.irq_en = apb_req.pwdata[`EOPT_ST_W-1:0];
        `EOPT_OFS_IRQ_CLR: ev_clr = apb_req.pwdata[`EOPT_ST_W-1:0];
        default: nxt_st.rdata = st_ff.rdata;
      endcase
    end
    // Set wins over clear
    nxt_st.status = (st_ff.status & ~ev_clr) | ev_set;

    if (setup) begin
      case (apb_req.paddr)
        `EOPT_OFS_CTRL: nxt_st.rdata = {31'h0, st_ff.line_mode};
        `EOPT_OFS_OFFSET: nxt_st.rdata = {{16{st_ff.offset[15]}}, st_ff.offset};
        `EOPT_OFS_GAIN: nxt_st.rdata = {{20{st_ff.gain[11]}}, st_ff.gain};
        `EOPT_OFS_PHASE: nxt_st.rdata = {{26{st_ff.phase[5]}}, st_ff.phase};
        `EOPT_OFS_NUM: nxt_st.rdata = {20'h0, st_ff.num};
        `EOPT_OFS_DEN: nxt_st.rdata = {20'h0, st_ff.den};
        `EOPT_OFS_HCYC: nxt_st.rdata = {16'h0, st_ff.hcyc_set};
        `EOPT_OFS_ENERGY: nxt_st.rdata = {8'h0, st_ff.energy_rd};
        `EOPT_OFS_LENERGY: nxt_st.rdata = {8'h0, st_ff.line_energy};
        `EOPT_OFS_STATUS: nxt_st.rdata = {29'h0, st_ff.status};
        `EOPT_OFS_IRQ_EN: nxt_st.rdata = {29'h0, st_ff.irq_en};
        default: nxt_st.rdata = 32'h0;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.phase <= `EOPT_RST_PHASE;
      st_ff.num <= `EOPT_RST_NUM;
      st_ff.den <= `EOPT_RST_DEN;
      st_ff.hcyc_set <= `EOPT_RST_HCYC;
      st_ff.lstate <= eopt_pkg::LC_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.rdata;
  assign energy_pulse_output = st_ff.pulse;
  assign irq_n = ~(|(st_ff.status & st_ff.irq_en));

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_acc_step;
    en4 |=> st_ff.acc == $past(acc_sum);
  endproperty
  a_acc_step: assert property (p_acc_step) else $error("acc step wrong");

  property p_acc_hold;
    !en4 |=> $stable(st_ff.acc) && $stable(st_ff.energy_rd);
  endproperty
  a_acc_hold: assert property (p_acc_hold) else $error("acc moved off step");

  property p_step_rate;
    en4 |=> !en4 [*3] ##1 en4;
  endproperty
  a_step_rate: assert property (p_step_rate) else $error("step rate wrong");

  property p_neg_offset;
    (en4 && gp == 32'sh0 && st_ff.offset < 16'sh0) |=> st_ff.acc < $past(st_ff.acc);
  endproperty
  a_neg_offset: assert property (p_neg_offset) else $error("negative offset");

  property p_frac_offset;
    (en4 && gp == 32'sh0 && st_ff.offset == 16'sh0001) |=>
      st_ff.acc - $past(st_ff.acc) == 57'sh1;
  endproperty
  a_frac_offset: assert property (p_frac_offset) else $error("offset lsb");

  property p_unity_gain;
    st_ff.gain == 12'sh0 |-> gp == st_ff.power;
  endproperty
  a_unity_gain: assert property (p_unity_gain) else $error("unity gain");

  property p_phase_mid;
    st_ff.phase == `EOPT_PHASE_MID |-> vsel == csel;
  endproperty
  a_phase_mid: assert property (p_phase_mid) else $error("phase mid shift");

  property p_pulse_div;
    energy_pulse_output |-> $past(en4) && st_ff.pulse_acc <= {1'b0, $past(st_ff.den)};
  endproperty
  a_pulse_div: assert property (p_pulse_div) else $error("pulse ratio");

  property p_line_irq;
    ($rose(st_ff.status[`EOPT_ST_LINE_DONE]) && st_ff.irq_en[`EOPT_ST_LINE_DONE])
      |-> !irq_n;
  endproperty
  a_line_irq: assert property (p_line_irq) else $error("line irq missing");

  property p_phase_delay;
    st_ff.phase > $signed(`EOPT_PHASE_MID) |-> vsel > csel;
  endproperty
  a_phase_delay: assert property (p_phase_delay) else $error("phase delay");

  property p_phase_advance;
    st_ff.phase < $signed(`EOPT_PHASE_MID) |-> vsel < csel;
  endproperty
  a_phase_advance: assert property (p_phase_advance) else $error("phase advance");

  property p_pulse_width;
    energy_pulse_output |=> !energy_pulse_output;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse too long");

  property p_pulse_rise;
    energy_pulse_output |-> st_ff.energy_rd == $past(st_ff.energy_rd) + 24'h000001;
  endproperty
  a_pulse_rise: assert property (p_pulse_rise) else $error("pulse without step");

  property p_neg_flag;
    (en4 && acc_sum[`EOPT_ACC_W-1] && !st_ff.acc[`EOPT_ACC_W-1])
      |=> st_ff.status[`EOPT_ST_NEG];
  endproperty
  a_neg_flag: assert property (p_neg_flag) else $error("negative flag");

  property p_status_sticky;
    (st_ff.status[`EOPT_ST_LINE_DONE] && !(wr && apb_req.paddr == `EOPT_OFS_IRQ_CLR))
      |=> st_ff.status[`EOPT_ST_LINE_DONE];
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("status lost");

  property p_line_result;
    ev_set[`EOPT_ST_LINE_DONE] |=>
      st_ff.line_energy == $past(st_ff.energy_rd - st_ff.line_start);
  endproperty
  a_line_result: assert property (p_line_result) else $error("line energy");

  c_pulse: cover property (energy_pulse_output);
  c_line_done: cover property ($rose(st_ff.status[`EOPT_ST_LINE_DONE]));
  c_advance: cover property (en8 && st_ff.phase < $signed(`EOPT_PHASE_MID));
  c_delay: cover property (en8 && st_ff.phase > $signed(`EOPT_PHASE_MID));
  c_gain_trim: cover property (en4 && st_ff.gain != 12'sh000);

endmodule // eopt_core

// [test/eopt_testbench.sv]
`timescale 1ns/1ps
`include "eopt_defines.svh"

module testbench;
  logic pclk;
  logic presetn;
  eopt_pkg::eopt_apb_req_t req;
  eopt_pkg::eopt_sample_t sample;
  logic zero_cross;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic energy_pulse_output;
  logic irq_n;
  logic smp_en;
  int fail_count;
  int total_checks;
  logic [31:0] mdl [0:11];
  logic [31:0] rd;
  logic er;
  logic cnt_en;
  int pulse_cnt;

  eopt_core i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(req),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .sample(sample),
    .zero_cross(zero_cross),
    .energy_pulse_output(energy_pulse_output),
    .irq_n(irq_n)
  );

  // ==========================================================
  // Clock, stimulus of samples, watchdog
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (smp_en) begin
      sample <= eopt_pkg::eopt_sample_t'($urandom);
    end
  end

  always @(posedge pclk) begin
    if (!cnt_en) begin
      pulse_cnt <= 0;
    end else if (energy_pulse_output) begin
      pulse_cnt <= pulse_cnt + 1;
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    finish_test();
  end

  // ==========================================================
  // Shared tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, rd, er);
    check(rd, exp);
  endtask

  task do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task toggle_zx();
    zero_cross <= ~zero_cross;
    repeat (12) @(posedge pclk);
  endtask

  // Two energy reads 256 clocks apart, pulses counted between them
  task energy_win(input int g, input int num, input int den);
    logic [31:0] e0;
    longint n_exp;
    n_exp = e_model(g, 64);
    wr(`EOPT_OFS_GAIN, 32'(g));
    wr(`EOPT_OFS_NUM, 32'(num));
    wr(`EOPT_OFS_DEN, 32'(den));
    repeat (40) @(posedge pclk);
    apb(1'b0, `EOPT_OFS_ENERGY, 32'h0000_0000, rd, er);
    e0 = rd;
    cnt_en <= 1'b1;
    repeat (253) @(posedge pclk);
    apb(1'b0, `EOPT_OFS_ENERGY, 32'h0000_0000, rd, er);
    cnt_en <= 1'b0;
    @(posedge pclk);
    check(rd - e0, 32'(n_exp));
    check(32'(pulse_cnt), 32'(n_exp * (num + 1) / (den + 1)));
  endtask

  task finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // Register model
  function automatic logic [31:0] fold(input logic [7:0] a, input logic [31:0] d);
    case (a)
      `EOPT_OFS_CTRL: fold = {31'h0, d[0]};
      `EOPT_OFS_OFFSET: fold = {{16{d[15]}}, d[15:0]};
      `EOPT_OFS_GAIN: fold = {{20{d[11]}}, d[11:0]};
      `EOPT_OFS_PHASE: fold = {{26{d[5]}}, d[5:0]};
      `EOPT_OFS_NUM, `EOPT_OFS_DEN: fold = {20'h0, d[11:0]};
      `EOPT_OFS_HCYC: fold = {16'h0, d[15:0]};
      `EOPT_OFS_IRQ_EN: fold = {29'h0, d[2:0]};
      default: fold = 32'h0000_0000;
    endcase
  endfunction

  // Energy LSBs after a number of steps at full-scale power
  function automatic longint e_model(input longint g, input longint steps);
    longint p;
    p = 64'sd32768 * 64'sd32768;
    e_model = (steps * ((p * (4096 + g)) / 4096)) / (64'sd1 << 33);
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] a;
    logic [31:0] d;
    presetn = 1'b0;
    req = '0;
    sample = '0;
    zero_cross = 1'b0;
    smp_en = 1'b0;
    fail_count = 0;
    cnt_en = 1'b0;
    total_checks = 0;
    void'($urandom(12));
    for (int i = 0; i < 12; i++) begin
      mdl[i] = 32'h0000_0000;
    end
    mdl[`EOPT_OFS_PHASE >> 2] = 32'h0000_000D;
    mdl[`EOPT_OFS_NUM >> 2] = 32'h0000_003F;
    mdl[`EOPT_OFS_DEN >> 2] = 32'h0000_003F;
    do_reset();
    repeat (20) @(posedge pclk);
    // Reset values, zero power gives no energy
    for (int i = 0; i < 12; i++) begin
      rd_chk(8'(i * 4), mdl[i]);
    end
    check({31'h0, irq_n}, 32'h0000_0001);
    // Signed read-back of trims, random and boundary values
    smp_en <= 1'b1;
    for (int k = 0; k < 24; k++) begin
      a = 8'((k % 7) * 4);
      d = (k < 7) ? 32'hFFFF_FFFF : ((k < 14) ? 32'h0000_0800 : $urandom);
      if (a == `EOPT_OFS_CTRL) begin
        d[0] = 1'b0;
      end
      wr(a, d);
      mdl[a >> 2] = fold(a, d);
      rd_chk(a, mdl[a >> 2]);
    end
    // Unmapped and unaligned places refuse, clear register reads zero
    apb(1'b0, 8'h30, 32'h0000_0000, rd, er);
    check({er, rd[30:0]}, 32'h8000_0000);
    apb(1'b0, 8'h05, 32'h0000_0000, rd, er);
    check({31'h0, er}, 32'h0000_0001);
    rd_chk(`EOPT_OFS_IRQ_CLR, 32'h0000_0000);
    // Second reset mid-run, then line-cycle accumulation
    smp_en <= 1'b0;
    @(posedge pclk);
    sample <= '0;
    do_reset();
    rd_chk(`EOPT_OFS_OFFSET, 32'h0000_0000);
    wr(`EOPT_OFS_HCYC, 32'h0000_0002);
    wr(`EOPT_OFS_IRQ_EN, 32'h0000_0001);
    wr(`EOPT_OFS_CTRL, 32'h0000_0001);
    toggle_zx();
    toggle_zx();
    apb(1'b0, `EOPT_OFS_STATUS, 32'h0000_0000, rd, er);
    check({31'h0, rd[0]}, 32'h0000_0000);
    check({31'h0, irq_n}, 32'h0000_0001);
    toggle_zx();
    apb(1'b0, `EOPT_OFS_STATUS, 32'h0000_0000, rd, er);
    check({31'h0, rd[0]}, 32'h0000_0001);
    check({31'h0, irq_n}, 32'h0000_0000);
    rd_chk(`EOPT_OFS_LENERGY, 32'h0000_0000);
    // Mask, unmask, clear
    wr(`EOPT_OFS_IRQ_EN, 32'h0000_0000);
    @(posedge pclk);
    check({31'h0, irq_n}, 32'h0000_0001);
    wr(`EOPT_OFS_IRQ_EN, 32'h0000_0001);
    @(posedge pclk);
    check({31'h0, irq_n}, 32'h0000_0000);
    wr(`EOPT_OFS_IRQ_CLR, 32'h0000_0001);
    @(posedge pclk);
    check({31'h0, irq_n}, 32'h0000_0001);
    apb(1'b0, `EOPT_OFS_STATUS, 32'h0000_0000, rd, er);
    check({31'h0, rd[0]}, 32'h0000_0000);
    check({31'h0, energy_pulse_output}, 32'h0000_0000);
    // Constant full-scale power, energy and pulses per gain and ratio
    sample <= '{volt: 16'sh8000, curr: 16'sh8000};
    repeat (300) @(posedge pclk);
    energy_win(0, 63, 63);
    energy_win(1024, 63, 63);
    energy_win(-2048, 63, 63);
    energy_win(0, 0, 1);
    finish_test();
  end
endmodule // testbench
